// ==== logic/spwid_regs.sv ====
// Plug-and-play identity register set of the router
`timescale 1ns/10ps
// Operation
// - A 32-bit owner identifier resets to zero and zero means no owner.
// - A disconnected or disabled owner port also means no owner.
// - Only a successful compare-and-swap changes the owner identifier.
// - Maker and item codes reset to zero, are written only locally.
// - A nonzero write of maker or item code sets the unit-valid flag.
// - The serial value resets to zero and is written only locally.
// - Vendor text length reads as a constant zero word.
// - Product text length reads as a constant zero word.
// - Protocol total reads as zero in bits 4:0, zero above.
// - Application total reads as zero in bits 7:0, zero above.
// - Owner, unit codes and serial sit at words 0x8, 0x9 and 0xA.
// - The unit-valid flag reads zero after reset.
// - The owner port records the port of the last successful swap.
module spwid_regs
	import spwid_pkg::*;
(
	input  wire logic        i_core_clk,
	input  wire logic        i_nrst,
	input  wire logic        i_pnp_rd,
	input  wire logic [31:0] i_pnp_addr,
	output logic             o_pnp_rvalid,
	output logic      [31:0] o_pnp_rdata,
	input  wire logic        i_pnp_wr,
	input  wire logic [31:0] i_pnp_wdata,
	input  wire logic        i_loc_wr,
	input  wire logic [31:0] i_loc_addr,
	input  wire logic [31:0] i_loc_wdata,
	input  wire logic        i_cas_req,
	input  wire logic [31:0] i_cas_cmp,
	input  wire logic [31:0] i_cas_new,
	input  wire logic [4:0]  i_cas_port,
	output logic             o_cas_done,
	output logic             o_cas_ok,
	output logic      [31:0] o_cas_old,
	input  wire logic [12:0] i_port_conn,
	input  wire logic [12:0] i_port_off_flag,
	output logic      [31:0] o_owner_identifier,
	output logic      [4:0]  o_owner_port,
	output logic             o_has_owner,
	output logic             o_unit_valid
);

	// ------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------
	logic rst_s1_ff;
	logic rst_s2_ff;
	logic rst_n;

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			rst_s1_ff <= 1'b0;
			rst_s2_ff <= 1'b0;
		end else begin
			rst_s1_ff <= 1'b1;
			rst_s2_ff <= rst_s1_ff;
		end
	end
	assign rst_n = rst_s2_ff;

	// ------------------------------------------------------------
	// Owner state through swap engine
	// ------------------------------------------------------------
	spwid_if cif ();
	logic    port_ok;
	logic    link_up;
	logic    link_off;
	logic    ownerless;

	always_comb begin
		port_ok  = (cif.owner_port <= SPWID_PORT_MAX);
		link_up  = port_ok ? i_port_conn[cif.owner_port[3:0]] : 1'b0;
		link_off = port_ok ? i_port_off_flag[cif.owner_port[3:0]] : 1'b1;
		ownerless = (cif.owner_identifier == SPWID_OWNER_RST)
			|| !link_up || link_off;
	end

	assign cif.req       = i_cas_req;
	assign cif.cmp       = i_cas_cmp;
	assign cif.new_val   = i_cas_new;
	assign cif.port      = i_cas_port;
	assign cif.ownerless = ownerless;

	spwid_cas u_cas (
		.i_core_clk (i_core_clk),
		.i_rst_n    (rst_n),
		.bus        (cif.cas)
	);

	// ------------------------------------------------------------
	// Unit identity
	// ------------------------------------------------------------
	logic [31:0] unit_ff;
	logic [31:0] nxt_unit;
	logic [31:0] serial_ff;
	logic [31:0] nxt_serial;
	logic        uval_ff;
	logic        nxt_uval;

	always_comb begin
		nxt_unit   = unit_ff;
		nxt_serial = serial_ff;
		nxt_uval   = uval_ff;
		if (i_loc_wr && i_loc_addr == SPWID_ADDR_UNIT) begin
			nxt_unit = i_loc_wdata;
			if (i_loc_wdata != SPWID_UNIT_RST) begin
				nxt_uval = 1'b1;
			end
		end else if (i_loc_wr && i_loc_addr == SPWID_ADDR_SERIAL) begin
			nxt_serial = i_loc_wdata;
		end
	end

	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			unit_ff   <= SPWID_UNIT_RST;
			serial_ff <= SPWID_SERIAL_RST;
			uval_ff   <= 1'b0;
		end else begin
			unit_ff   <= nxt_unit;
			serial_ff <= nxt_serial;
			uval_ff   <= nxt_uval;
		end
	end

	// ------------------------------------------------------------
	// Plug-and-play read port
	// ------------------------------------------------------------
	logic        rv_ff;
	logic        nxt_rv;
	logic [31:0] rd_ff;
	logic [31:0] nxt_rd;

	always_comb begin
		nxt_rv = i_pnp_rd;
		nxt_rd = rd_ff;
		if (i_pnp_rd) begin
			if (i_pnp_addr == SPWID_ADDR_OWNER) begin
				nxt_rd = cif.owner_identifier;
			end else if (i_pnp_addr == SPWID_ADDR_UNIT) begin
				nxt_rd = {unit_ff[31:SPWID_MAKER_LSB],
					unit_ff[SPWID_ITEM_MSB:0]};
			end else if (i_pnp_addr == SPWID_ADDR_SERIAL) begin
				nxt_rd = serial_ff;
			end else if (i_pnp_addr == SPWID_ADDR_VLEN) begin
				nxt_rd = {17'h0_0000, SPWID_VLEN_VAL};
			end else if (i_pnp_addr == SPWID_ADDR_PLEN) begin
				nxt_rd = {17'h0_0000, SPWID_PLEN_VAL};
			end else if (i_pnp_addr == SPWID_ADDR_PCNT) begin
				nxt_rd = {27'h000_0000, SPWID_PCNT_VAL};
			end else if (i_pnp_addr == SPWID_ADDR_ACNT) begin
				nxt_rd = {24'h00_0000, SPWID_ACNT_VAL};
			end else begin
				nxt_rd = SPWID_RSVD_RD;
			end
		end
	end

	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rv_ff <= 1'b0;
			rd_ff <= SPWID_RSVD_RD;
		end else begin
			rv_ff <= nxt_rv;
			rd_ff <= nxt_rd;
		end
	end

	// Plug-and-play writes carry no effect
	logic pnp_wr_seen;
	assign pnp_wr_seen = i_pnp_wr && (i_pnp_wdata != SPWID_RSVD_RD);

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign o_pnp_rvalid       = rv_ff;
	assign o_pnp_rdata        = rd_ff;
	assign o_cas_done         = cif.done;
	assign o_cas_ok           = cif.ok;
	assign o_cas_old          = cif.old_val;
	assign o_owner_identifier = cif.owner_identifier;
	assign o_owner_port       = cif.owner_port;
	assign o_has_owner        = !ownerless;
	assign o_unit_valid       = uval_ff;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!rst_n);

	a_owner_zero_free: assert property (
		o_owner_identifier == SPWID_OWNER_RST |-> !o_has_owner)
		else $error("zero owner seen as owned");
	a_port_off_free: assert property (
		(o_owner_port <= SPWID_PORT_MAX
		&& (i_port_off_flag[o_owner_port[3:0]]
		|| !i_port_conn[o_owner_port[3:0]])) |-> !o_has_owner)
		else $error("dead owner port seen as owned");
	a_plain_wr_keep: assert property (
		(i_loc_wr || pnp_wr_seen) && !i_cas_req
		|=> $stable(o_owner_identifier))
		else $error("plain write changed owner");
	a_cas_swap_ok: assert property (
		i_cas_req ##1 o_cas_ok
		|-> o_owner_identifier == $past(i_cas_new))
		else $error("swap did not store new owner");
	a_unit_wr_read: assert property (
		i_loc_wr && i_loc_addr == SPWID_ADDR_UNIT ##1 !i_loc_wr
		##1 i_pnp_rd && i_pnp_addr == SPWID_ADDR_UNIT && !i_loc_wr
		|=> o_pnp_rdata == $past(i_loc_wdata, 3))
		else $error("unit codes not written");
	a_unit_valid_set: assert property (
		i_loc_wr && i_loc_addr == SPWID_ADDR_UNIT
		&& i_loc_wdata != SPWID_UNIT_RST
		|=> o_unit_valid [*2])
		else $error("unit valid flag not set");
	a_serial_rd: assert property (
		i_pnp_rd && i_pnp_addr == SPWID_ADDR_SERIAL
		|=> o_pnp_rvalid && o_pnp_rdata == $past(serial_ff))
		else $error("serial read wrong");
	a_const_rd_zero: assert property (
		i_pnp_rd && (i_pnp_addr == SPWID_ADDR_VLEN
		|| i_pnp_addr == SPWID_ADDR_PLEN
		|| i_pnp_addr == SPWID_ADDR_PCNT
		|| i_pnp_addr == SPWID_ADDR_ACNT)
		|=> o_pnp_rvalid && o_pnp_rdata == SPWID_RSVD_RD)
		else $error("constant word not zero");
	a_owner_rd: assert property (
		i_pnp_rd && i_pnp_addr == SPWID_ADDR_OWNER
		|=> o_pnp_rdata == $past(o_owner_identifier))
		else $error("owner read wrong");
	a_uval_reset: assert property (
		$rose(rst_n) |-> !o_unit_valid)
		else $error("unit valid set at reset");

	c_cas_win: cover property (i_cas_req ##1 o_cas_ok);
	c_unit_set: cover property ($rose(o_unit_valid));
	c_owner_lost: cover property ($fell(o_has_owner));

endmodule

// ==== pkg/spwid_pkg.sv ====
// Constants for the plug-and-play identity register set
package spwid_pkg;

	// ------------------------------------------------------------
	// Word addresses in the plug-and-play space
	// ------------------------------------------------------------
	localparam logic [31:0] SPWID_ADDR_OWNER  = 32'h0000_0008;
	localparam logic [31:0] SPWID_ADDR_UNIT   = 32'h0000_0009;
	localparam logic [31:0] SPWID_ADDR_SERIAL = 32'h0000_000A;
	localparam logic [31:0] SPWID_ADDR_VLEN   = 32'h0000_4000;
	localparam logic [31:0] SPWID_ADDR_PLEN   = 32'h0000_6000;
	localparam logic [31:0] SPWID_ADDR_PCNT   = 32'h0000_8000;
	localparam logic [31:0] SPWID_ADDR_ACNT   = 32'h0000_C000;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [31:0] SPWID_OWNER_RST  = 32'h0000_0000;
	localparam logic [31:0] SPWID_UNIT_RST   = 32'h0000_0000;
	localparam logic [31:0] SPWID_SERIAL_RST = 32'h0000_0000;
	localparam logic [4:0]  SPWID_PORT_RST   = 5'h00;

	// ------------------------------------------------------------
	// Field layouts and constant fields
	// ------------------------------------------------------------
	localparam int          SPWID_MAKER_LSB = 16;
	localparam int          SPWID_ITEM_MSB  = 15;
	localparam logic [14:0] SPWID_VLEN_VAL  = 15'h0000;
	localparam logic [14:0] SPWID_PLEN_VAL  = 15'h0000;
	localparam logic [4:0]  SPWID_PCNT_VAL  = 5'h00;
	localparam logic [7:0]  SPWID_ACNT_VAL  = 8'h00;
	localparam logic [31:0] SPWID_RSVD_RD   = 32'h0000_0000;

	// ------------------------------------------------------------
	// Router ports
	// ------------------------------------------------------------
	localparam int          SPWID_PORT_CNT = 13;
	localparam logic [4:0]  SPWID_PORT_MAX = 5'h0C;

endpackage

// ==== pkg/spwid_if.sv ====
// Carrier between the register set and its swap engine
`timescale 1ns/10ps
interface spwid_if;
	logic        req;
	logic [31:0] cmp;
	logic [31:0] new_val;
	logic [4:0]  port;
	logic        ownerless;
	logic        done;
	logic        ok;
	logic [31:0] old_val;
	logic [31:0] owner_identifier;
	logic [4:0]  owner_port;

	modport regs (
		output req,
		output cmp,
		output new_val,
		output port,
		output ownerless,
		input  done,
		input  ok,
		input  old_val,
		input  owner_identifier,
		input  owner_port
	);

	modport cas (
		input  req,
		input  cmp,
		input  new_val,
		input  port,
		input  ownerless,
		output done,
		output ok,
		output old_val,
		output owner_identifier,
		output owner_port
	);
endinterface

// ==== logic/spwid_cas.sv ====
// Compare-and-swap engine holding the owner identifier and owner port
`timescale 1ns/10ps
module spwid_cas
	import spwid_pkg::*;
(
	input  wire logic i_core_clk,
	input  wire logic i_rst_n,
	spwid_if.cas      bus
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic [31:0] owner_ff;
	logic [31:0] nxt_owner;
	logic [4:0]  oport_ff;
	logic [4:0]  nxt_oport;
	logic        done_ff;
	logic        nxt_done;
	logic        ok_ff;
	logic        nxt_ok;
	logic [31:0] old_ff;
	logic [31:0] nxt_old;
	logic [31:0] eff_owner;
	logic        match;

	// ------------------------------------------------------------
	// Next values
	// ------------------------------------------------------------
	always_comb begin
		eff_owner = bus.ownerless ? SPWID_OWNER_RST : owner_ff;
		match     = (eff_owner == bus.cmp);
		nxt_owner = owner_ff;
		nxt_oport = oport_ff;
		nxt_done  = bus.req;
		nxt_ok    = 1'b0;
		nxt_old   = old_ff;
		if (bus.req) begin
			nxt_old = eff_owner;
			nxt_ok  = match;
			if (match) begin
				nxt_owner = bus.new_val;
				nxt_oport = bus.port;
			end
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			owner_ff <= SPWID_OWNER_RST;
			oport_ff <= SPWID_PORT_RST;
			done_ff  <= 1'b0;
			ok_ff    <= 1'b0;
			old_ff   <= SPWID_OWNER_RST;
		end else begin
			owner_ff <= nxt_owner;
			oport_ff <= nxt_oport;
			done_ff  <= nxt_done;
			ok_ff    <= nxt_ok;
			old_ff   <= nxt_old;
		end
	end

	assign bus.owner_identifier = owner_ff;
	assign bus.owner_port       = oport_ff;
	assign bus.done             = done_ff;
	assign bus.ok               = ok_ff;
	assign bus.old_val          = old_ff;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);

	a_cas_port_rec: assert property (ok_ff |-> oport_ff == $past(bus.port))
		else $error("owner port not taken from swap");
	a_cas_only_upd: assert property (!$past(bus.req) |-> $stable(owner_ff))
		else $error("owner changed without swap");
	c_cas_fail: cover property (bus.req ##1 (done_ff && !ok_ff));

endmodule

// ==== dv/spwid_initiator.sv ====
// Remote initiator model issuing plug-and-play reads, writes and swaps
`timescale 1ns/10ps
module spwid_initiator (
	input  wire logic        i_core_clk,
	input  wire logic        i_rvalid,
	input  wire logic [31:0] i_rdata,
	input  wire logic        i_done,
	input  wire logic        i_ok,
	input  wire logic [31:0] i_old,
	output logic             o_rd,
	output logic             o_wr,
	output logic             o_req,
	output logic      [31:0] o_addr,
	output logic      [31:0] o_wdata,
	output logic      [31:0] o_cmp,
	output logic      [31:0] o_new,
	output logic      [4:0]  o_port
);
	// ------------------------------------------------------------
	// Idle values and commands
	// ------------------------------------------------------------
	initial begin
		o_rd = 1'b0;
		o_wr = 1'b0;
		o_req = 1'b0;
		o_addr = 32'h0000_0000;
		o_wdata = 32'h0000_0000;
		o_cmp = 32'h0000_0000;
		o_new = 32'h0000_0000;
		o_port = 5'h00;
	end
	task automatic pnp_read(input logic [31:0] a, input int slow,
		output logic [31:0] d, output logic v);
		repeat (slow) @(posedge i_core_clk);
		@(posedge i_core_clk);
		#1 o_rd = 1'b1;
		o_addr = a;
		@(posedge i_core_clk);
		#1 o_rd = 1'b0;
		o_addr = ~a;
		v = i_rvalid;
		d = i_rdata;
	endtask
	task automatic pnp_write(input logic [31:0] d);
		@(posedge i_core_clk);
		#1 o_wr = 1'b1;
		o_wdata = d;
		@(posedge i_core_clk);
		#1 o_wr = 1'b0;
		o_wdata = ~d;
	endtask
	task automatic swap(input logic [31:0] c, input logic [31:0] n,
		input logic [4:0] p, output logic dn, output logic ok,
		output logic [31:0] old);
		@(posedge i_core_clk);
		#1 o_req = 1'b1;
		o_cmp = c;
		o_new = n;
		o_port = p;
		@(posedge i_core_clk);
		#1 o_req = 1'b0;
		o_cmp = ~c;
		o_new = ~n;
		o_port = ~p;
		dn = i_done;
		ok = i_ok;
		old = i_old;
	endtask
endmodule

// ==== dv/tb_spacewire_pnp_identity_regs.sv ====
// Self-checking bench for the plug-and-play identity register set
`timescale 1ns/10ps
`define CHK(got, exp) \
	begin \
		checked++; \
		if ((got) !== (exp)) begin \
			failures++; \
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp); \
		end \
	end
module tb_spacewire_pnp_identity_regs;
	import spwid_pkg::*;
	logic        clk, nrst, rd, wr, req, rvalid, done, ok, lwr_s, has, uval;
	logic [31:0] addr, wdata, rdata, cmp, nw, old, laddr, ldata, own_id;
	logic [31:0] own, r, seed;
	logic [4:0]  port, own_port, oport;
	logic [12:0] conn, off;
	logic        uvalid;
	int          failures, checked, cycles, slow;
	logic [31:0] cadr [8] = '{SPWID_ADDR_OWNER, SPWID_ADDR_UNIT,
		SPWID_ADDR_SERIAL, SPWID_ADDR_VLEN, SPWID_ADDR_PLEN,
		SPWID_ADDR_PCNT, SPWID_ADDR_ACNT, 32'h0000_0003};

	spwid_regs spwid_regs_inst (.i_core_clk(clk), .i_nrst(nrst),
		.i_pnp_rd(rd), .i_pnp_addr(addr), .o_pnp_rvalid(rvalid),
		.o_pnp_rdata(rdata), .i_pnp_wr(wr), .i_pnp_wdata(wdata),
		.i_loc_wr(lwr_s), .i_loc_addr(laddr), .i_loc_wdata(ldata),
		.i_cas_req(req), .i_cas_cmp(cmp), .i_cas_new(nw),
		.i_cas_port(port), .o_cas_done(done), .o_cas_ok(ok),
		.o_cas_old(old), .i_port_conn(conn), .i_port_off_flag(off),
		.o_owner_identifier(own_id), .o_owner_port(oport),
		.o_has_owner(has), .o_unit_valid(uval));
	spwid_initiator spwid_initiator_inst (.i_core_clk(clk),
		.i_rvalid(rvalid), .i_rdata(rdata), .i_done(done), .i_ok(ok),
		.i_old(old), .o_rd(rd), .o_wr(wr), .o_req(req), .o_addr(addr),
		.o_wdata(wdata), .o_cmp(cmp), .o_new(nw), .o_port(port));

	// ------------------------------------------------------------
	// Clock, timeout, expectations and helpers
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			complete_run();
		end
	end
	task automatic complete_run();
		if (failures == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic owned();
		if (own == 32'h0000_0000 || own_port > SPWID_PORT_MAX)
			return 1'b0;
		return conn[own_port] & ~off[own_port];
	endfunction
	task automatic do_reset();
		@(posedge clk);
		#1 nrst = 1'b0;
		repeat (4) @(posedge clk);
		#1 nrst = 1'b1;
		repeat (3) @(posedge clk);
		#1 own = SPWID_OWNER_RST;
		own_port = SPWID_PORT_RST;
		uvalid = 1'b0;
		`CHK(own_id, own)
		`CHK(oport, own_port)
		`CHK(uval, 1'b0)
		`CHK(has, 1'b0)
	endtask
	task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic        v;
		spwid_initiator_inst.pnp_read(a, slow, d, v);
		`CHK(v, 1'b1)
		`CHK(d, e)
	endtask
	task automatic lwr(input logic [31:0] a, input logic [31:0] d);
		@(posedge clk);
		#1 lwr_s = 1'b1;
		laddr = a;
		ldata = d;
		@(posedge clk);
		#1 lwr_s = 1'b0;
		laddr = ~a;
		ldata = ~d;
		if (a == SPWID_ADDR_UNIT && d != 32'h0000_0000)
			uvalid = 1'b1;
		`CHK(uval, uvalid)
	endtask
	task automatic do_cas(input logic [31:0] c, input logic [31:0] n,
		input logic [4:0] p);
		logic [31:0] eff, o;
		logic        dn, k;
		eff = owned() ? own : 32'h0000_0000;
		spwid_initiator_inst.swap(c, n, p, dn, k, o);
		`CHK(dn, 1'b1)
		`CHK(k, c == eff)
		`CHK(o, eff)
		if (c == eff) begin
			own = n;
			own_port = p;
		end
		`CHK(own_id, own)
		`CHK(oport, own_port)
		`CHK(has, owned())
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	initial begin
		seed = 32'h0000_579A;
		nrst = 1'b0;
		lwr_s = 1'b0;
		laddr = 32'h0000_0000;
		ldata = 32'h0000_0000;
		conn = 13'h1FFF;
		off = 13'h0000;
		slow = 0;
		do_reset();
		foreach (cadr[i]) rd_chk(cadr[i], SPWID_RSVD_RD);
		lwr(SPWID_ADDR_UNIT, 32'h0000_0000);
		lwr(SPWID_ADDR_UNIT, 32'h0000_00A5);
		rd_chk(SPWID_ADDR_UNIT, 32'h0000_00A5);
		r = rnd();
		lwr(SPWID_ADDR_SERIAL, r);
		rd_chk(SPWID_ADDR_SERIAL, r);
		lwr(SPWID_ADDR_OWNER, 32'hFFFF_0001);
		lwr(SPWID_ADDR_PCNT, 32'hFFFF_FFFF);
		rd_chk(SPWID_ADDR_OWNER, 32'h0000_0000);
		rd_chk(SPWID_ADDR_PCNT, 32'h0000_0000);
		spwid_initiator_inst.pnp_write(32'hDEAD_BEEF);
		rd_chk(SPWID_ADDR_SERIAL, r);
		rd_chk(SPWID_ADDR_UNIT, 32'h0000_00A5);
		rd_chk(SPWID_ADDR_OWNER, SPWID_OWNER_RST);
		lwr(SPWID_ADDR_UNIT, 32'h5A5A_0000);
		rd_chk(SPWID_ADDR_UNIT, 32'h5A5A_0000);
		lwr(SPWID_ADDR_UNIT, 32'h0000_0000);
		rd_chk(SPWID_ADDR_UNIT, 32'h0000_0000);
		do_cas(32'h0000_0000, 32'h0000_1234, 5'h03);
		off[3] = 1'b1;
		do_cas(32'h0000_1234, 32'h0000_9999, 5'h05);
		do_cas(32'h0000_0000, 32'h0000_5678, 5'h0C);
		conn[12] = 1'b0;
		do_cas(32'h0000_0000, 32'h0000_ABCD, 5'h0D);
		do_cas(32'h0000_0000, 32'h0000_0000, 5'h00);
		repeat (150) begin
			r = rnd();
			conn = r[12:0] | r[25:13];
			off = r[25:13] & r[31:19];
			slow = int'(r[31:30]);
			do_cas(r[27] ? (owned() ? own : 32'h0000_0000) :
				(r[28] ? 32'h0000_0000 : rnd()), rnd(),
				5'(r[9:0] % 14));
			rd_chk(SPWID_ADDR_OWNER, own);
		end
		do_reset();
		rd_chk(SPWID_ADDR_UNIT, SPWID_UNIT_RST);
		rd_chk(SPWID_ADDR_SERIAL, SPWID_SERIAL_RST);
		r = rnd();
		lwr(SPWID_ADDR_SERIAL, r);
		rd_chk(SPWID_ADDR_SERIAL, r);
		complete_run();
	end
endmodule
